// *** common/uttl_pkg.sv ***
// constants shared by the underreach transfer-trip block
package uttl_pkg;
   // timing
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned TICK_TIME_PS  = 1000000000;
   localparam int unsigned TICK_CYCLES   = TICK_TIME_PS / CLK_PERIOD_PS;
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CONTROL    = 8'h00;
   localparam logic [7:0] OFS_DIR_HOLD   = 8'h04;
   localparam logic [7:0] OFS_PERM_HOLD  = 8'h08;
   localparam logic [7:0] OFS_PERM_QUAL  = 8'h0C;
   localparam logic [7:0] OFS_STATE      = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
   // control fields
   localparam int unsigned CTL_DIR_EN     = 0;
   localparam int unsigned CTL_PERM_EN    = 1;
   localparam int unsigned CTL_DIR_BITS   = 4;
   localparam int unsigned CTL_PERM_BITS  = 6;
   // channel bit count codes
   localparam logic [1:0] BITS_ONE  = 2'h0;
   localparam logic [1:0] BITS_TWO  = 2'h1;
   localparam logic [1:0] BITS_FOUR = 2'h2;
   // trip vector positions
   localparam int unsigned TRIP_A  = 0;
   localparam int unsigned TRIP_B  = 1;
   localparam int unsigned TRIP_C  = 2;
   localparam int unsigned TRIP_3P = 3;
   // interrupt event bits
   localparam int unsigned EV_DIR_OP   = 0;
   localparam int unsigned EV_PERM_OP  = 1;
   localparam int unsigned EV_PERM_RX  = 2;
   localparam int unsigned EV_COUNT    = 3;
   // reset values, the hold and qualify times in milliseconds
   localparam logic [15:0] DIR_HOLD_RST  = 16'h000A;
   localparam logic [15:0] PERM_HOLD_RST = 16'h000A;
   localparam logic [15:0] PERM_QUAL_RST = 16'h0000;
   localparam logic [31:0] CONTROL_RST   = 32'h0000_0000;
endpackage

// *** hw/uttl_top.sv ***
// underreach transfer-trip logic, direct and permissive schemes
`timescale 1ns/10ps

module uttl_top #(
   parameter int unsigned TICK_CYCLES = uttl_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   // local protection inputs
   input  wire logic        zone1_pickup,
   input  wire logic        zone2_pickup,
   input  wire logic [2:0]  phase_select,
   // receive inputs
   input  wire logic [3:0]  direct_receive_bit,
   input  wire logic [3:0]  permissive_receive_bit,
   // direct scheme outputs
   output logic [3:0]       direct_transmit_bit,
   output logic             direct_scheme_operate,
   output logic [3:0]       direct_phase_trip,
   // permissive scheme outputs
   output logic [3:0]       permissive_transmit_bit,
   output logic             permissive_scheme_operate,
   output logic [3:0]       permissive_phase_trip,
   // interrupt
   output logic             irq
);

   // input synchronisers
   logic [12:0] sync1_reg;
   logic [12:0] sync2_reg;
   logic        z1_s;
   logic        z2_s;
   logic [2:0]  sel_s;
   logic [3:0]  rx_s [2];

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_reg <= 13'h0000;
         sync2_reg <= 13'h0000;
      end
      else if (clk_en)
      begin
         sync1_reg <= {zone1_pickup, zone2_pickup, phase_select,
                       direct_receive_bit, permissive_receive_bit};
         sync2_reg <= sync1_reg;
      end
   end

   assign z1_s     = sync2_reg[12];
   assign z2_s     = sync2_reg[11];
   assign sel_s    = sync2_reg[10:8];
   assign rx_s[0]  = sync2_reg[7:4];
   assign rx_s[1]  = sync2_reg[3:0];

   // registers
   logic [31:0] control_reg;
   logic [15:0] dir_hold_reg;
   logic [15:0] perm_hold_reg;
   logic [15:0] perm_qual_reg;
   logic [uttl_pkg::EV_COUNT-1:0] irq_status_reg;
   logic [uttl_pkg::EV_COUNT-1:0] irq_enable_reg;
   logic [uttl_pkg::EV_COUNT-1:0] event_pulse;
   logic [31:0] rdata_next;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         control_reg   <= uttl_pkg::CONTROL_RST;
         dir_hold_reg  <= uttl_pkg::DIR_HOLD_RST;
         perm_hold_reg <= uttl_pkg::PERM_HOLD_RST;
         perm_qual_reg <= uttl_pkg::PERM_QUAL_RST;
         irq_enable_reg <= '0;
      end
      else if (clk_en && reg_write)
      begin
         unique case (reg_addr)
            uttl_pkg::OFS_CONTROL:    control_reg   <= reg_wdata;
            uttl_pkg::OFS_DIR_HOLD:   dir_hold_reg  <= reg_wdata[15:0];
            uttl_pkg::OFS_PERM_HOLD:  perm_hold_reg <= reg_wdata[15:0];
            uttl_pkg::OFS_PERM_QUAL:  perm_qual_reg <= reg_wdata[15:0];
            uttl_pkg::OFS_IRQ_ENABLE:
               irq_enable_reg <= reg_wdata[uttl_pkg::EV_COUNT-1:0];
            default: ;
         endcase
      end
   end

   // sticky status, set beats clear
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         irq_status_reg <= '0;
      else if (clk_en)
      begin
         if (reg_write && reg_addr == uttl_pkg::OFS_IRQ_CLEAR)
            irq_status_reg <= (irq_status_reg & ~reg_wdata[uttl_pkg::EV_COUNT-1:0])
                              | event_pulse;
         else
            irq_status_reg <= irq_status_reg | event_pulse;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         irq <= 1'b0;
      else if (clk_en)
         irq <= |(irq_status_reg & irq_enable_reg);
   end

   // millisecond tick
   logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
   logic                             tick;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         tick_cnt_reg <= '0;
      else if (clk_en)
      begin
         if (tick)
            tick_cnt_reg <= '0;
         else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
   end

   assign tick = (tick_cnt_reg == ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1));

   // per-scheme logic: 0 direct, 1 permissive
   logic        en     [2];
   logic [1:0]  bits   [2];
   logic [15:0] hold   [2];
   logic        op_reg [2];
   logic [3:0]  tx_reg [2];
   logic [3:0]  trip_reg [2];
   logic        rx_ok  [2];
   logic        op_prev_reg [2];

   assign en[0]   = control_reg[uttl_pkg::CTL_DIR_EN];
   assign en[1]   = control_reg[uttl_pkg::CTL_PERM_EN];
   assign bits[0] = control_reg[uttl_pkg::CTL_DIR_BITS +: 2];
   assign bits[1] = control_reg[uttl_pkg::CTL_PERM_BITS +: 2];
   assign hold[0] = dir_hold_reg;
   assign hold[1] = perm_hold_reg;

   // permissive receive qualification
   logic [16:0] qual_cnt_reg;
   logic        perm_rx_any;
   logic        perm_rx_prev_reg;

   always_comb
   begin
      unique case (bits[1])
         uttl_pkg::BITS_TWO:  perm_rx_any = |rx_s[1][1:0];
         uttl_pkg::BITS_FOUR: perm_rx_any = |rx_s[1];
         default:             perm_rx_any = rx_s[1][0];
      endcase
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         qual_cnt_reg <= '0;
      else if (clk_en)
      begin
         if (!en[1] || !perm_rx_any)
            qual_cnt_reg <= '0;
         else if (tick && qual_cnt_reg <= {1'b0, perm_qual_reg})
            qual_cnt_reg <= qual_cnt_reg + 17'h00001;
      end
   end

   // a partial first tick does not count toward the delay
   assign rx_ok[1] = en[1] && perm_rx_any
                     && (perm_qual_reg == 16'h0000
                         || qual_cnt_reg > {1'b0, perm_qual_reg});
   assign rx_ok[0] = en[0] && (bits[0] == uttl_pkg::BITS_TWO  ? |rx_s[0][1:0] :
                               bits[0] == uttl_pkg::BITS_FOUR ? |rx_s[0] :
                               rx_s[0][0]);

   genvar s;
   generate
      for (s = 0; s < 2; s++)
      begin : g_scheme
         logic [3:0]  code;
         logic [3:0]  remote;
         logic [2:0]  phases;
         logic [3:0]  trip_next;
         logic        cond;
         logic [16:0] seal_cnt_reg;

         // transmit code from local phase selector
         always_comb
         begin
            code = 4'h0;
            unique case (bits[s])
               uttl_pkg::BITS_TWO:
               begin
                  code[0] = sel_s[0] | sel_s[2];
                  code[1] = sel_s[1] | sel_s[2];
               end
               uttl_pkg::BITS_FOUR:
               begin
                  code[2:0] = sel_s;
                  code[3]   = (sel_s[0] & sel_s[1]) | (sel_s[1] & sel_s[2])
                              | (sel_s[0] & sel_s[2]);
               end
               default: code[0] = 1'b1;
            endcase
         end

         // remote fault type decode
         always_comb
         begin
            remote = 4'h0;
            unique case (bits[s])
               uttl_pkg::BITS_TWO:
               begin
                  remote[0] = rx_s[s][0] & ~rx_s[s][1];
                  remote[1] = rx_s[s][1] & ~rx_s[s][0];
                  remote[2] = rx_s[s][0] & rx_s[s][1];
               end
               uttl_pkg::BITS_FOUR: remote = rx_s[s];
               default: remote = 4'h0;
            endcase
         end

         // trip table
         assign phases = sel_s | remote[2:0];
         always_comb
         begin
            trip_next = 4'h0;
            if (remote[3] || (phases != 3'h1 && phases != 3'h2 && phases != 3'h4))
               trip_next[uttl_pkg::TRIP_3P] = 1'b1;
            else
               trip_next[2:0] = phases;
         end

         if (s == 0)
         begin : g_dir
            assign cond = rx_ok[0];
         end
         else
         begin : g_perm
            assign cond = rx_ok[1] && z2_s;
         end

         // keying on zone 1
         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               tx_reg[s] <= 4'h0;
            else if (clk_en)
               tx_reg[s] <= (en[s] && z1_s) ? code : 4'h0;
         end

         // operate with seal
         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
            begin
               op_reg[s]       <= 1'b0;
               seal_cnt_reg    <= '0;
               trip_reg[s]     <= 4'h0;
               op_prev_reg[s]  <= 1'b0;
            end
            else if (clk_en)
            begin
               op_prev_reg[s] <= op_reg[s];
               if (!en[s])
               begin
                  op_reg[s]    <= 1'b0;
                  seal_cnt_reg <= '0;
                  trip_reg[s]  <= 4'h0;
               end
               else if (cond)
               begin
                  op_reg[s]    <= 1'b1;
                  // one tick more, so a partial first tick cannot shorten it
                  seal_cnt_reg <= (hold[s] == 16'h0000) ? 17'h00000
                                  : {1'b0, hold[s]} + 17'h00001;
                  trip_reg[s]  <= trip_next;
               end
               else if (seal_cnt_reg != 17'h00000)
               begin
                  op_reg[s] <= 1'b1;
                  if (tick)
                     seal_cnt_reg <= seal_cnt_reg - 17'h00001;
               end
               else
               begin
                  op_reg[s]   <= 1'b0;
                  trip_reg[s] <= 4'h0;
               end
            end
         end
      end
   endgenerate

   // events
   assign event_pulse[uttl_pkg::EV_DIR_OP]  = op_reg[0] & ~op_prev_reg[0];
   assign event_pulse[uttl_pkg::EV_PERM_OP] = op_reg[1] & ~op_prev_reg[1];
   assign event_pulse[uttl_pkg::EV_PERM_RX] = rx_ok[1] & ~perm_rx_prev_reg;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         perm_rx_prev_reg <= 1'b0;
      else if (clk_en)
         perm_rx_prev_reg <= rx_ok[1];
   end

   // output mapping
   assign direct_transmit_bit       = tx_reg[0];
   assign permissive_transmit_bit   = tx_reg[1];
   assign direct_scheme_operate     = op_reg[0];
   assign permissive_scheme_operate = op_reg[1];
   assign direct_phase_trip         = trip_reg[0];
   assign permissive_phase_trip     = trip_reg[1];

   // read data
   always_comb
   begin
      unique case (reg_addr)
         uttl_pkg::OFS_CONTROL:    rdata_next = control_reg;
         uttl_pkg::OFS_DIR_HOLD:   rdata_next = {16'h0000, dir_hold_reg};
         uttl_pkg::OFS_PERM_HOLD:  rdata_next = {16'h0000, perm_hold_reg};
         uttl_pkg::OFS_PERM_QUAL:  rdata_next = {16'h0000, perm_qual_reg};
         uttl_pkg::OFS_STATE:
            rdata_next = {8'h00, trip_reg[1], trip_reg[0], tx_reg[1], tx_reg[0],
                          5'h00, rx_ok[1], op_reg[1], op_reg[0]};
         uttl_pkg::OFS_IRQ_STATUS:
            rdata_next = {{(32-uttl_pkg::EV_COUNT){1'b0}}, irq_status_reg};
         uttl_pkg::OFS_IRQ_ENABLE:
            rdata_next = {{(32-uttl_pkg::EV_COUNT){1'b0}}, irq_enable_reg};
         default:                  rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 32'h0000_0000;
      else if (clk_en)
         reg_rdata <= reg_read ? rdata_next : 32'h0000_0000;
   end

endmodule

// *** verification/uttl_properties.sv ***
// assertion checker on the transfer-trip block ports
`timescale 1ns/10ps
module uttl_properties (
   // clock and reset
   input wire logic       clock,
   input wire logic       arst_n,
   // local pickups
   input wire logic       zone1_pickup,
   input wire logic       zone2_pickup,
   // scheme outputs
   input wire logic [3:0] direct_transmit_bit,
   input wire logic       direct_scheme_operate,
   input wire logic [3:0] direct_phase_trip,
   input wire logic [3:0] permissive_transmit_bit,
   input wire logic       permissive_scheme_operate,
   input wire logic [3:0] permissive_phase_trip
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence dir_held_s;
      direct_scheme_operate [*8];
   endsequence
   sequence perm_held_s;
      ##1 permissive_scheme_operate [*8];
   endsequence
   AST_DIR_TX_CAUSE: assert property (direct_transmit_bit != 4'h0 |-> $past(zone1_pickup, 3))
      else $error("direct transmit without zone 1 pickup");
   AST_PERM_OP_ZONE2: assert property ($rose(permissive_scheme_operate) |-> $past(zone2_pickup, 3))
      else $error("permissive operate without zone 2");
   AST_PERM_TX_CAUSE: assert property (permissive_transmit_bit != 4'h0 |-> $past(zone1_pickup, 3))
      else $error("permissive transmit without zone 1 pickup");
   AST_DIR_HOLD: assert property ($rose(direct_scheme_operate) |-> dir_held_s)
      else $error("direct operate shorter than hold");
   AST_PERM_HOLD: assert property ($rose(permissive_scheme_operate) |-> perm_held_s)
      else $error("permissive operate shorter than hold");
   AST_DIR_TRIP_ON_OP: assert property ($rose(direct_scheme_operate) |-> direct_phase_trip != 4'h0)
      else $error("direct operate without trip");
   AST_DIR_TRIP_SEAL: assert property ($fell(direct_scheme_operate) |-> direct_phase_trip == 4'h0)
      else $error("direct trip outlives operate");
   AST_PERM_TRIP_OP: assert property (permissive_phase_trip != 4'h0 |-> permissive_scheme_operate)
      else $error("permissive trip without operate");
endmodule

// *** verification/uttl_remote_model.sv ***
// remote terminal model driving the receive channel bits
`timescale 1ns/10ps
module uttl_remote_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // remote terminal keying
   input  wire logic       key_a,
   input  wire logic       key_b,
   input  wire logic [3:0] code,
   // channel bits toward the block
   output logic      [3:0] rx_direct,
   output logic      [3:0] rx_permissive
);
   // released contacts read low
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_direct     <= 4'h0;
         rx_permissive <= 4'h0;
      end
      else
      begin
         rx_direct     <= (key_a && key_b) ? code : 4'h0;
         rx_permissive <= (key_a || key_b) ? code : 4'h0;
      end
   end
endmodule

// *** verification/uttl_top_bench.sv ***
// self-checking bench for the transfer-trip block
`timescale 1ns/10ps
module uttl_top_bench;
   localparam int TICK = 4;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic        zone1_pickup = 1'b0;
   logic        zone2_pickup = 1'b0;
   logic [2:0]  phase_select = 3'h0;
   logic        key_a = 1'b0;
   logic        key_b = 1'b0;
   logic [3:0]  code = 4'h0;
   logic [3:0]  rxd, rxp, dtx, dtrip, ptx, ptrip;
   logic        dop, pop, irq;
   int          error_cnt = 0;
   int          tests_run = 0;
   // count, phases, remote code, transmit, trips
   logic [19:0] rows [8] = '{20'h01111, 20'h06118, 20'h11218, 20'h12222,
                             20'h11111, 20'h24444, 20'h21818, 20'h233B8};
   uttl_remote_model far (.clock(clock), .arst_n(arst_n), .key_a(key_a), .key_b(key_b),
      .code(code), .rx_direct(rxd), .rx_permissive(rxp));
   uttl_top #(.TICK_CYCLES(TICK)) uut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .zone1_pickup(zone1_pickup),
      .zone2_pickup(zone2_pickup), .phase_select(phase_select), .direct_receive_bit(rxd),
      .permissive_receive_bit(rxp), .direct_transmit_bit(dtx), .direct_scheme_operate(dop),
      .direct_phase_trip(dtrip), .permissive_transmit_bit(ptx),
      .permissive_scheme_operate(pop), .permissive_phase_trip(ptrip), .irq(irq));
   always #2.5 clock = ~clock;
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic send(input logic a, input logic b, input int n);
      @(posedge clock);
      key_a <= a;
      key_b <= b;
      cyc(n);
      key_a <= 1'b0;
      key_b <= 1'b0;
   endtask
   task automatic settle();
      @(posedge clock);
      zone1_pickup <= 1'b0;
      key_a <= 1'b0;
      key_b <= 1'b0;
      for (int i = 0; i < 300; i++)
      begin
         @(posedge clock);
         #1;
         if (dop === 1'b0 && pop === 1'b0)
            return;
      end
      error_cnt++;
      $display("[FAIL] %0t operate never released", $time);
      wrap_up();
   endtask
   initial
   begin
      logic [19:0] r;
      int          nd;
      int          np;
      cyc(16);
      arst_n <= 1'b1;
      rd(uttl_pkg::OFS_DIR_HOLD, 32'h0000_000A);
      rd(uttl_pkg::OFS_PERM_HOLD, 32'h0000_000A);
      rd(uttl_pkg::OFS_PERM_QUAL, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      wr(uttl_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
      foreach (rows[i])
      begin
         r = rows[i];
         wr(uttl_pkg::OFS_CONTROL, {24'h0, r[17:16], r[17:16], 4'h3});
         phase_select <= r[14:12];
         code         <= r[11:8];
         zone1_pickup <= 1'b1;
         zone2_pickup <= 1'b1;
         key_a        <= 1'b1;
         key_b        <= 1'b1;
         cyc(8);
         #1;
         chk(32'({dtx, ptx}), 32'({r[7:4], r[7:4]}));
         chk(32'({dtrip, ptrip, dop, pop}), 32'({r[3:0], r[3:0], 2'h3}));
         settle();
      end
      #1;
      chk(32'(irq), 32'h1);
      // seal-in lengths from a one-cycle receive pulse
      wr(uttl_pkg::OFS_PERM_HOLD, 32'h0000_0003);
      send(1'b1, 1'b1, 1);
      nd = 0;
      np = 0;
      repeat (80)
      begin
         @(posedge clock);
         #1;
         if (dop === 1'b1)
            nd++;
         if (pop === 1'b1)
            np++;
      end
      chk(32'(nd >= 10 * TICK && nd <= 11 * TICK + 4), 32'h1);
      chk(32'(np >= 3 * TICK && np <= 4 * TICK + 4), 32'h1);
      wr(uttl_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
      cyc(2);
      #1;
      chk(32'(irq), 32'h0);
      rd(uttl_pkg::OFS_IRQ_STATUS, 32'h0000_0006);
      // short receive refused, long accepted, one copy only
      wr(uttl_pkg::OFS_IRQ_ENABLE, 32'h0);
      wr(uttl_pkg::OFS_PERM_QUAL, 32'h0000_0002);
      send(1'b1, 1'b0, 7);
      cyc(12);
      #1;
      chk(32'({dop, pop}), 32'h0);
      send(1'b1, 1'b0, 20);
      cyc(4);
      #1;
      chk(32'({dop, pop}), 32'h1);
      settle();
      zone2_pickup <= 1'b0;
      send(1'b1, 1'b1, 20);
      cyc(3);
      #1;
      chk(32'({dop, pop}), 32'h2);
      chk(32'(irq), 32'h0);
      rd(uttl_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      // disabled schemes stay silent
      settle();
      wr(uttl_pkg::OFS_CONTROL, 32'h0);
      zone1_pickup <= 1'b1;
      zone2_pickup <= 1'b1;
      send(1'b1, 1'b1, 8);
      #1;
      chk(32'({dtx, ptx, dtrip, ptrip, dop, pop}), 32'h0);
      // reset in mid-operation
      wr(uttl_pkg::OFS_CONTROL, 32'h0000_0003);
      key_a <= 1'b1;
      key_b <= 1'b1;
      cyc(20);
      #1;
      chk(32'({dop, pop}), 32'h3);
      // clock enable low freezes the seal-in timers
      key_a  <= 1'b0;
      key_b  <= 1'b0;
      clk_en <= 1'b0;
      cyc(60);
      #1;
      chk(32'({dop, pop}), 32'h3);
      clk_en <= 1'b1;
      arst_n <= 1'b0;
      #1;
      chk(32'({dtx, ptx, dtrip, ptrip, dop, pop}), 32'h0);
      @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      #1;
      chk(32'({dtx, ptx, dtrip, ptrip, dop, pop}), 32'h0);
      wrap_up();
   end
endmodule
bind uttl_top uttl_properties props (.clock(clock), .arst_n(arst_n),
   .zone1_pickup(zone1_pickup), .zone2_pickup(zone2_pickup),
   .direct_transmit_bit(direct_transmit_bit), .direct_scheme_operate(direct_scheme_operate),
   .direct_phase_trip(direct_phase_trip), .permissive_transmit_bit(permissive_transmit_bit),
   .permissive_scheme_operate(permissive_scheme_operate),
   .permissive_phase_trip(permissive_phase_trip));
